//--- rtl/isf_params.svh
// constants for the interrupt source flag block: offsets, field positions, reset values
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// ----------------------------------------------------------------------------
// register indices (printed offsets) and apb byte addresses
// ----------------------------------------------------------------------------
`define ISF_PADDR_W 18
`define ISF_IDX_PEND_LOW 16'hfe04
`define ISF_IDX_PEND_MID 16'hfe05
`define ISF_IDX_PEND_HIGH 16'hfe06
`define ISF_IDX_SERIAL_CTRL 16'hfe08
`define ISF_ADDR_PEND_LOW ({`ISF_IDX_PEND_LOW, 2'b00})
`define ISF_ADDR_PEND_MID ({`ISF_IDX_PEND_MID, 2'b00})
`define ISF_ADDR_PEND_HIGH ({`ISF_IDX_PEND_HIGH, 2'b00})
`define ISF_ADDR_SERIAL_CTRL ({`ISF_IDX_SERIAL_CTRL, 2'b00})

// ----------------------------------------------------------------------------
// serial error control register fields
// ----------------------------------------------------------------------------
`define ISF_CTRL_FE_IE 0
`define ISF_CTRL_PE_IE 1
`define ISF_CTRL_FE_FLAG 2
`define ISF_CTRL_PE_FLAG 3
`define ISF_CTRL_IE_RESET 2'b00

// ----------------------------------------------------------------------------
// pending flag numbering (flag n sits at vector bit n)
// ----------------------------------------------------------------------------
`define ISF_PF_EXT_ONE 1
`define ISF_PF_CLOCK_GEN 2
`define ISF_PF_DMA 3
`define ISF_PF_TIMER_CH0 4
`define ISF_PF_TIMER_OVF 8
`define ISF_PF_SPI_RX 9
`define ISF_PF_SPI_TX 10
`define ISF_PF_SERIAL_ERR 11
`define ISF_PF_SERIAL_RX 12
`define ISF_PF_SERIAL_TX 13
`define ISF_PF_EXT_TWO 14
`define ISF_PF_KEYPAD 15
`define ISF_PEND_RESET 15'h0000
`define ISF_LOW_ZERO_BITS 2'b00
`define ISF_HIGH_ZERO_BITS 7'h00
`define ISF_PIN_IDLE 1'b1

`endif

//--- rtl/isf_pkg.sv
// types shared by the interrupt source flag block
package isf_pkg;

   // ----------------------------------------------------------------------------
   // register select decoded from the apb address
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ISF_SEL_NONE = 3'b000,
      ISF_SEL_LOW = 3'b001,
      ISF_SEL_MID = 3'b010,
      ISF_SEL_HIGH = 3'b011,
      ISF_SEL_CTRL = 3'b100
   } isf_sel_t;

   // pending flags 15..1, bit 0 unused so that flag n is bit n
   typedef logic [15:1] isf_pend_t;

endpackage : isf_pkg

//--- rtl/isf_pin_latch.sv
// synchronises active-low request pins and latches any low level until acknowledged
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_pin_latch #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins, active low, asynchronous
   input wire logic [WIDTH-1:0] pins_n,
   // service acknowledge from the cpu side
   input wire logic ack,
   // latched request
   output logic request
);

   // ----------------------------------------------------------------------------
   // two-stage synchroniser
   // ----------------------------------------------------------------------------
   logic [WIDTH-1:0] syncFirst;
   logic [WIDTH-1:0] syncSecond;
   wire anyLow = ~(&syncSecond);
   wire next_request = anyLow | (request & ~ack);

   // reset to the idle level so that release cannot fake a request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncFirst <= {WIDTH{`ISF_PIN_IDLE}};
         syncSecond <= {WIDTH{`ISF_PIN_IDLE}};
      end else begin
         syncFirst <= pins_n;
         syncSecond <= syncFirst;
      end
   end

   // ----------------------------------------------------------------------------
   // request latch: a low level in the ack cycle wins over the ack
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         request <= 1'b0;
      end else begin
         request <= next_request;
      end
   end

endmodule : isf_pin_latch

//--- rtl/isf_serial_err.sv
// serial receiver framing and parity error flags and the gated serial error request
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_serial_err (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // receiver samples
   input wire logic stopBitStrobe,
   input wire logic stopBitLevel,
   input wire logic parityStrobe,
   input wire logic parityFail,
   // enables and clears
   input wire logic framingErrorIrqEnable,
   input wire logic parityErrorIrqEnable,
   input wire logic framingClear,
   input wire logic parityClear,
   // other serial error sources, already gated by their own enables
   input wire logic otherErrReq,
   // flags and request
   output logic framingErrorFlag,
   output logic parityErrorFlag,
   output logic serialErrReq
);

   // ----------------------------------------------------------------------------
   // flags: set wins over a clear in the same cycle
   // ----------------------------------------------------------------------------
   // low stop bit
   wire framingSet = stopBitStrobe & ~stopBitLevel;
   wire paritySet = parityStrobe & parityFail;
   wire next_framing = framingSet | (framingErrorFlag & ~framingClear);
   wire next_parity = paritySet | (parityErrorFlag & ~parityClear);
   wire framingReq = framingErrorFlag & framingErrorIrqEnable;
   wire parityReq = parityErrorFlag & parityErrorIrqEnable;
   wire next_errReq = framingReq | parityReq | otherErrReq;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         framingErrorFlag <= 1'b0;
         parityErrorFlag <= 1'b0;
      end else begin
         framingErrorFlag <= next_framing;
         parityErrorFlag <= next_parity;
      end
   end

   // combinational so the pending flag follows the flag by exactly one register
   assign serialErrReq = next_errReq;

endmodule : isf_serial_err

//--- rtl/isf_top.sv
// interrupt source flags: pending flag collection, status bytes over apb, cpu requests
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_top (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ISF_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // on-chip peripheral requests, already gated by their own enables
   input wire logic clockGenReq,
   input wire logic dmaReq,
   input wire logic [3:0] timerChanReq,
   input wire logic timerOvfReq,
   input wire logic spiRxReq,
   input wire logic spiTxReq,
   input wire logic serialOtherErrReq,
   input wire logic serialRxReq,
   input wire logic serialTxReq,
   // serial receiver samples
   input wire logic stopBitStrobe,
   input wire logic stopBitLevel,
   input wire logic parityStrobe,
   input wire logic parityFail,
   // external pins, active low
   input wire logic extPinOne_n,
   input wire logic extPinTwo_n,
   input wire logic [7:0] keypadPins_n,
   // pin request acknowledges from the cpu
   input wire logic extOneAck,
   input wire logic extTwoAck,
   input wire logic keypadAck,
   // cpu side
   input wire logic globalMask,
   input wire logic softwareInterruptInstr,
   output logic cpuIrq,
   output logic cpuSwi,
   output isf_pkg::isf_pend_t pendFlags
);

   // ----------------------------------------------------------------------------
   // pin request latches
   // ----------------------------------------------------------------------------
   logic extOneReq;
   logic extTwoReq;
   logic keypadReq;

   isf_pin_latch #(.WIDTH(1)) uExtOne (
      .clk(clk),
      .reset_n(reset_n),
      .pins_n(extPinOne_n),
      .ack(extOneAck),
      .request(extOneReq)
   );

   isf_pin_latch #(.WIDTH(1)) uExtTwo (
      .clk(clk),
      .reset_n(reset_n),
      .pins_n(extPinTwo_n),
      .ack(extTwoAck),
      .request(extTwoReq)
   );

   isf_pin_latch #(.WIDTH(8)) uKeypad (
      .clk(clk),
      .reset_n(reset_n),
      .pins_n(keypadPins_n),
      .ack(keypadAck),
      .request(keypadReq)
   );

   // ----------------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------------
   logic [1:0] serialIrqEnable;
   logic framingErrorFlag;
   logic parityErrorFlag;
   logic serialErrReq;

   wire setupPhase = psel & ~penable;
   wire accessPhase = psel & penable;
   wire hitLow = (paddr == `ISF_ADDR_PEND_LOW);
   wire hitMid = (paddr == `ISF_ADDR_PEND_MID);
   wire hitHigh = (paddr == `ISF_ADDR_PEND_HIGH);
   wire hitCtrl = (paddr == `ISF_ADDR_SERIAL_CTRL);
   wire isf_pkg::isf_sel_t sel = hitLow ? isf_pkg::ISF_SEL_LOW :
                                 hitMid ? isf_pkg::ISF_SEL_MID :
                                 hitHigh ? isf_pkg::ISF_SEL_HIGH :
                                 hitCtrl ? isf_pkg::ISF_SEL_CTRL : isf_pkg::ISF_SEL_NONE;
   wire unmapped = (sel == isf_pkg::ISF_SEL_NONE);
   // only the control word is writable; status writes fall through
   wire ctrlWrite = accessPhase & pwrite & (sel == isf_pkg::ISF_SEL_CTRL) & pstrb[0];
   wire framingClear = ctrlWrite & pwdata[`ISF_CTRL_FE_FLAG];
   wire parityClear = ctrlWrite & pwdata[`ISF_CTRL_PE_FLAG];
   wire [1:0] next_serialIrqEnable = ctrlWrite ? pwdata[`ISF_CTRL_PE_IE:`ISF_CTRL_FE_IE] : serialIrqEnable;

   // ----------------------------------------------------------------------------
   // serial error flags
   // ----------------------------------------------------------------------------
   isf_serial_err uSerialErr (
      .clk(clk),
      .reset_n(reset_n),
      .stopBitStrobe(stopBitStrobe),
      .stopBitLevel(stopBitLevel),
      .parityStrobe(parityStrobe),
      .parityFail(parityFail),
      .framingErrorIrqEnable(serialIrqEnable[`ISF_CTRL_FE_IE]),
      .parityErrorIrqEnable(serialIrqEnable[`ISF_CTRL_PE_IE]),
      .framingClear(framingClear),
      .parityClear(parityClear),
      .otherErrReq(serialOtherErrReq),
      .framingErrorFlag(framingErrorFlag),
      .parityErrorFlag(parityErrorFlag),
      .serialErrReq(serialErrReq)
   );

   // ----------------------------------------------------------------------------
   // pending flag vector
   // ----------------------------------------------------------------------------
   // source order, flag n at bit n
   wire isf_pkg::isf_pend_t next_pend = {
      keypadReq,
      extTwoReq,
      serialTxReq,
      serialRxReq,
      serialErrReq,
      spiTxReq,
      spiRxReq,
      timerOvfReq,
      timerChanReq[3],
      timerChanReq[2],
      timerChanReq[1],
      timerChanReq[0],
      dmaReq,
      clockGenReq,
      extOneReq
   };

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pendFlags <= `ISF_PEND_RESET;
      end else begin
         pendFlags <= next_pend;
      end
   end

   // ----------------------------------------------------------------------------
   // status bytes and read data
   // ----------------------------------------------------------------------------
   // flags 6..1 in bits 7..2
   wire [7:0] lowByte = {pendFlags[6:1], `ISF_LOW_ZERO_BITS};
   wire [7:0] midByte = pendFlags[14:7];
   // flag 15 in bit 0, rest zero
   wire [7:0] highByte = {`ISF_HIGH_ZERO_BITS, pendFlags[15]};
   wire [7:0] ctrlByte = {4'h0, parityErrorFlag, framingErrorFlag, serialIrqEnable};
   wire [7:0] selByte = (sel == isf_pkg::ISF_SEL_LOW) ? lowByte :
                        (sel == isf_pkg::ISF_SEL_MID) ? midByte :
                        (sel == isf_pkg::ISF_SEL_HIGH) ? highByte :
                        (sel == isf_pkg::ISF_SEL_CTRL) ? ctrlByte : 8'h00;
   wire [31:0] next_prdata = setupPhase ? {24'h000000, selByte} : prdata;
   wire next_pslverr = setupPhase ? unmapped : pslverr;

   // read data is captured in the setup cycle so the zero-wait access sees a stable word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         serialIrqEnable <= `ISF_CTRL_IE_RESET;
      end else begin
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         serialIrqEnable <= next_serialIrqEnable;
      end
   end

   assign pready = 1'b1;

   // ----------------------------------------------------------------------------
   // cpu request outputs
   // ----------------------------------------------------------------------------
   // mask blocks maskable sources, never the software interrupt
   wire next_cpuIrq = (|pendFlags) & ~globalMask;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cpuIrq <= 1'b0;
         cpuSwi <= 1'b0;
      end else begin
         cpuIrq <= next_cpuIrq;
         cpuSwi <= softwareInterruptInstr;
      end
   end

endmodule : isf_top

//--- dv/isf_top_assertions.sv
// port-level checks for the interrupt source flag block
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_top_assertions (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ISF_PADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // sources and pins
   input wire logic clockGenReq,
   input wire logic dmaReq,
   input wire logic [3:0] timerChanReq,
   input wire logic timerOvfReq,
   input wire logic extPinTwo_n,
   input wire logic [7:0] keypadPins_n,
   input wire logic extTwoAck,
   // cpu side
   input wire logic globalMask,
   input wire logic softwareInterruptInstr,
   input wire logic cpuIrq,
   input wire logic cpuSwi,
   input wire isf_pkg::isf_pend_t pendFlags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire rdSetup = psel & ~penable & ~pwrite;

   property p_irq; cpuIrq == $past(|pendFlags & ~globalMask); endproperty
   a_irq: assert property (p_irq) else $error("maskable request gating wrong");
   property p_swi; cpuSwi == $past(softwareInterruptInstr); endproperty
   a_swi: assert property (p_swi) else $error("software interrupt blocked");
   property p_mirror; pendFlags[8:2] == $past({timerOvfReq, timerChanReq, dmaReq, clockGenReq}); endproperty
   a_mirror: assert property (p_mirror) else $error("peripheral flag mismatch");
   property p_two; !extPinTwo_n [*4] |=> pendFlags[14]; endproperty
   a_two: assert property (p_two) else $error("pin two request not latched");
   property p_hold; pendFlags[14] && !extTwoAck && !$past(extTwoAck) |=> pendFlags[14]; endproperty
   a_hold: assert property (p_hold) else $error("pin two request lost");
   property p_key; (keypadPins_n != 8'hff) [*4] |=> pendFlags[15]; endproperty
   a_key: assert property (p_key) else $error("keypad request not latched");
   property p_low; rdSetup && paddr == `ISF_ADDR_PEND_LOW |=> prdata == {24'h0, $past(pendFlags[6:1]), 2'b00}; endproperty
   a_low: assert property (p_low) else $error("low byte wrong");
   property p_mid; rdSetup && paddr == `ISF_ADDR_PEND_MID |=> prdata == {24'h0, $past(pendFlags[14:7])}; endproperty
   a_mid: assert property (p_mid) else $error("mid byte wrong");
   property p_high; rdSetup && paddr == `ISF_ADDR_PEND_HIGH |=> prdata == {31'h0, $past(pendFlags[15])}; endproperty
   a_high: assert property (p_high) else $error("high byte wrong");
   c_read: cover property (rdSetup && pready);
   c_serr: cover property (pendFlags[11]);
   c_swi: cover property (cpuSwi && globalMask);
endmodule : isf_top_assertions

bind isf_top isf_top_assertions u_chk (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .clockGenReq, .dmaReq, .timerChanReq, .timerOvfReq, .extPinTwo_n, .keypadPins_n, .extTwoAck,
   .globalMask, .softwareInterruptInstr, .cpuIrq, .cpuSwi, .pendFlags);

//--- dv/isf_cpu_model.sv
// cpu-side model: apb master for the status bytes, request acks, mask and software interrupt
`timescale 1ns/1ps
`include "isf_params.svh"

module isf_cpu_model (
   // clock
   input wire logic clk,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [`ISF_PADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // service
   output logic [2:0] ack,
   output logic globalMask,
   output logic softwareInterruptInstr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'hf;
      ack = 3'h0;
      globalMask = 1'b0;
      softwareInterruptInstr = 1'b0;
   end

   task automatic xfer(input logic w, input logic [`ISF_PADDR_W-1:0] a, input logic [31:0] d,
         output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines stop echoing the last request
      paddr <= ~a;
      pwdata <= ~d;
   endtask : xfer

   task automatic pulse(input int k);
      @(posedge clk);
      ack[k] <= 1'b1;
      @(posedge clk);
      ack[k] <= 1'b0;
   endtask : pulse
endmodule : isf_cpu_model

//--- dv/tb.sv
// self-checking bench for the interrupt source flag block
`timescale 1ns/1ps
`include "isf_params.svh"

module tb;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, e;
   logic [`ISF_PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [2:0] ack;
   logic globalMask, softwareInterruptInstr, cpuIrq, cpuSwi;
   logic [15:1] src;
   logic stopBitStrobe, stopBitLevel, parityStrobe, parityFail, extPinOne_n, extPinTwo_n;
   logic [7:0] keypadPins_n;
   isf_pkg::isf_pend_t pendFlags;
   int mismatches, check_count;

   isf_top uut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .clockGenReq(src[2]), .dmaReq(src[3]), .timerChanReq(src[7:4]), .timerOvfReq(src[8]),
      .spiRxReq(src[9]), .spiTxReq(src[10]), .serialOtherErrReq(src[11]), .serialRxReq(src[12]),
      .serialTxReq(src[13]), .stopBitStrobe, .stopBitLevel, .parityStrobe, .parityFail, .extPinOne_n,
      .extPinTwo_n, .keypadPins_n, .extOneAck(ack[0]), .extTwoAck(ack[1]), .keypadAck(ack[2]),
      .globalMask, .softwareInterruptInstr, .cpuIrq, .cpuSwi, .pendFlags);
   isf_cpu_model u_cpu (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .ack, .globalMask, .softwareInterruptInstr);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic cmp(input logic [32:0] g, input logic [32:0] x);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask : cmp

   task automatic rd(input logic [`ISF_PADDR_W-1:0] a, input logic [31:0] x, input logic xe);
      u_cpu.xfer(1'b0, a, 32'h0, q, e);
      cmp({e, q}, {xe, x});
   endtask : rd

   task automatic wr(input logic [`ISF_PADDR_W-1:0] a, input logic [31:0] d);
      u_cpu.xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic flags(input logic [15:1] x);
      rd(`ISF_ADDR_PEND_LOW, {24'h0, x[6:1], 2'b00}, 1'b0);
      rd(`ISF_ADDR_PEND_MID, {24'h0, x[14:7]}, 1'b0);
      rd(`ISF_ADDR_PEND_HIGH, {31'h0, x[15]}, 1'b0);
   endtask : flags

   // par selects the parity sample, v is the sampled stop level or the parity fail
   task automatic ser(input logic par, input logic v);
      @(posedge clk);
      stopBitStrobe <= !par;
      stopBitLevel <= v;
      parityStrobe <= par;
      parityFail <= v;
      @(posedge clk);
      stopBitStrobe <= 1'b0;
      parityStrobe <= 1'b0;
   endtask : ser

   task automatic pin(input logic [9:0] lo, input int k, input logic [15:1] x);
      @(posedge clk);
      {keypadPins_n, extPinTwo_n, extPinOne_n} <= lo;
      repeat (5) @(posedge clk);
      {keypadPins_n, extPinTwo_n, extPinOne_n} <= 10'h3ff;
      repeat (3) @(posedge clk);
      flags(x);
      u_cpu.pulse(k);
      flags('0);
   endtask : pin

   task automatic test_done;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   initial begin
      repeat (4000) @(posedge clk);
      mismatches++;
      test_done();
   end

   initial begin
      reset_n = 1'b0;
      src = '0;
      {stopBitStrobe, stopBitLevel, parityStrobe, parityFail} = 4'h4;
      {keypadPins_n, extPinTwo_n, extPinOne_n} = 10'h3ff;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      flags('0);
      rd(18'h0, 32'h0, 1'b1);
      for (int i = 2; i <= 13; i++) begin
         @(posedge clk);
         src <= 15'h1 << (i - 1);
         repeat (2) @(posedge clk);
         flags(15'h1 << (i - 1));
      end
      wr(`ISF_ADDR_PEND_MID, 32'hff);
      flags(15'h1000);
      cmp({32'h0, cpuIrq}, 33'h1);
      u_cpu.globalMask <= 1'b1;
      u_cpu.softwareInterruptInstr <= 1'b1;
      repeat (2) @(posedge clk);
      cmp({cpuIrq, cpuSwi}, 33'h1);
      u_cpu.globalMask <= 1'b0;
      u_cpu.softwareInterruptInstr <= 1'b0;
      src <= '0;
      // serial error flags against their enables
      wr(`ISF_ADDR_SERIAL_CTRL, 32'h1);
      ser(1'b0, 1'b1);
      rd(`ISF_ADDR_SERIAL_CTRL, 32'h1, 1'b0);
      ser(1'b0, 1'b0);
      rd(`ISF_ADDR_SERIAL_CTRL, 32'h5, 1'b0);
      flags(15'h400);
      wr(`ISF_ADDR_SERIAL_CTRL, 32'h0);
      ser(1'b1, 1'b0);
      flags('0);
      ser(1'b1, 1'b1);
      rd(`ISF_ADDR_SERIAL_CTRL, 32'hc, 1'b0);
      flags('0);
      wr(`ISF_ADDR_SERIAL_CTRL, 32'h2);
      flags(15'h400);
      wr(`ISF_ADDR_SERIAL_CTRL, 32'he);
      rd(`ISF_ADDR_SERIAL_CTRL, 32'h2, 1'b0);
      flags('0);
      pin(10'h3fe, 0, 15'h1);
      pin(10'h3fd, 1, 15'h2000);
      pin(10'h37f, 2, 15'h4000);
      // a second reset in mid-run clears everything
      src <= 15'h2;
      repeat (3) @(posedge clk);
      reset_n <= 1'b0;
      src <= '0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      flags('0);
      test_done();
   end
endmodule : tb
